//--- verilog/multichannel_dma_controller.sv
`timescale 1ns/1ns
`include "dma_regs.svh"
// Overview of operation
// - separate channels move data between memory and each peripheral port
// - every channel runs linear or row-and-column transfers
// - start from loaded parameters or from a fetched descriptor block
// - row and column counts reach 64K elements, zero meaning 64K
// - element and row steps are signed, up to 32K elements each way
// - row step may be smaller than element step for interleaving
// - single-buffer mode stops itself after the last element
// - autobuffer reloads at buffer end, interrupts per buffer or row
// - linked descriptors chain, next one fetched when current ends
// - descriptor array gives base addresses within one common page
// - two memory streams copy memory to memory
// - memory streams run from descriptors or autobuffer parameters
// - channel 0 video port, line 8, core interrupt 1
// - channels 1-4 serial ports, lines 9-12, core interrupt 2
// - channels 5,6 SPI ports, lines 13,14, core interrupt 3
// - channels 7,8 async serial rx/tx, lines 15,16, core interrupt 3
// - stream 0 is channels 12,13, line 29, core interrupt 6
// - stream 1 is channels 14,15, line 30, core interrupt 6
// - each interrupt line holds until acknowledged
// - async serial channels have low arbitration priority after reset
module multichannel_dma_controller (
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                cfg_we_i,
   input  wire logic [3:0]          cfg_ch_i,
   input  wire logic                cfg_desc_i,
   input  wire dma_pkg::chan_param_t cfg_param_i,
   input  wire logic                prio_we_i,
   input  wire logic [15:0]         prio_low_i,
   input  wire logic [8:0]          per_req_i,
   input  wire logic [31:0]         per_rdata_i,
   output logic [8:0]               per_sel_o,
   output logic [8:0]               per_ack_o,
   output logic [31:0]              per_wdata_o,
   output dma_pkg::mem_req_t        mem_o,
   input  wire logic                mem_gnt_i,
   input  wire logic                mem_rvalid_i,
   input  wire logic [31:0]         mem_rdata_i,
   input  wire logic                mem_err_i,
   input  wire logic [31:0]         irq_ack_i,
   output logic [31:0]              periph_irq_o,
   output logic [6:0]               core_irq_o,
   output logic [15:0]              active_o
);

   function automatic logic [16:0] cnt_load(input logic [15:0] c);
      return (c == '0) ? `CNT_FULL : {1'b0, c};
   endfunction : cnt_load

   function automatic logic [4:0] line_of(input logic [3:0] ch);
      if (ch < `DMA_NPER_CH) begin
         return `LINE_CH0 + {1'b0, ch};
      end
      return (ch < `DMA_MS1_FIRST) ? `LINE_MS0 : `LINE_MS1;
   endfunction : line_of

   function automatic logic [2:0] core_of(input logic [4:0] l);
      logic [2:0] r;
      r = `CORE_ERR;
      if (l == `LINE_CH0) r = `CORE_PPI;
      else if (l >= `LINE_SPORT_LO && l < `LINE_SPI_LO) r = `CORE_SPORT;
      else if (l >= `LINE_SPI_LO && l <= `LINE_UART_HI) r = `CORE_SPI_UART;
      else if (l == `LINE_MS0 || l == `LINE_MS1) r = `CORE_MEM;
      return r;
   endfunction : core_of

   function automatic logic [6:0] core_map(input logic [31:0] v);
      logic [6:0] r;
      r = '0;
      for (int l = 0; l < 32; l++) begin
         if (v[l]) r[core_of(5'(l))] = 1'b1;
      end
      return r;
   endfunction : core_map

   dma_pkg::chan_param_t param [`DMA_NCH];
   logic [31:0]          cur_addr [`DMA_NCH];
   logic [31:0]          desc_ptr [`DMA_NCH];
   logic [31:0]          nextp [`DMA_NCH];
   logic [16:0]          xcnt [`DMA_NCH];
   logic [16:0]          ycnt [`DMA_NCH];
   logic [15:0]          active;
   logic [15:0]          desc_pend;
   logic [15:0]          low_mask;
   logic [15:0]          req;
   logic [31:0]          irq_line;
   dma_pkg::eng_state_t  st;
   logic [3:0]           cur;
   logic [2:0]           fidx;

   wire                  gnt_v;
   wire [3:0]            gnt_ch;
   wire [3:0]            step_ch [2];
   wire [31:0]           s_addr [2];
   wire [16:0]           s_x [2];
   wire [16:0]           s_y [2];
   wire                  s_row [2];
   wire                  s_end [2];

   // arbitration and channel decode
   dma_arbiter u_arb (
      .req_i   (req),
      .low_i   (low_mask),
      .valid_o (gnt_v),
      .ch_o    (gnt_ch)
   );

   wire dma_pkg::chan_param_t pc = param[cur];
   wire dma_pkg::chan_param_t pg = param[gnt_ch];
   wire dma_pkg::chan_cfg_t fetched_cfg =
      dma_pkg::chan_cfg_t'(mem_rdata_i[`CFG_W-1:0]);
   wire [3:0]  pair        = cur | 4'h1;
   wire        is_stream   = (cur >= `DMA_MS_FIRST);
   wire        gnt_stream  = (gnt_ch >= `DMA_MS_FIRST);
   wire        gnt_rd      = gnt_stream | ~pg.cfg.to_mem;
   wire [8:0]  gnt_sel     = gnt_stream ? 9'h0 : 9'(9'h1 << gnt_ch);
   wire [2:0]  next_fidx   = fidx + 3'h1;
   wire [31:0] fetch_addr  = desc_ptr[cur] + 32'({next_fidx, 2'b00});
   wire        fetch_last  = (pc.cfg.flow == dma_pkg::FLOW_ARRAY) ?
                             (fidx == `DESC_LAST_ARRAY) :
                             (fidx == `DESC_LAST_LIST);
   wire        fetch_hit   = (st == dma_pkg::ST_FETCH) & mem_rvalid_i;
   wire        step_now    = (st == dma_pkg::ST_STEP);
   wire        abort       = mem_err_i & (st != dma_pkg::ST_IDLE);
   wire        cfg_ok      = (cfg_ch_i < `DMA_NPER_CH) |
                             (cfg_ch_i >= `DMA_MS_FIRST);
   wire        cfg_bad     = cfg_we_i & cfg_param_i.cfg.enable & ~cfg_ok;
   wire        done_end    = is_stream ? s_end[1] : s_end[0];
   wire        row_evt     = pc.cfg.irq_row &
                             (is_stream ? s_row[1] : s_row[0]);
   wire        done_irq    = step_now & ~abort &
                             ((done_end & pc.cfg.irq_en) | row_evt);
   wire [31:0] irq_set     = (cfg_bad | abort ? 32'h1 << `LINE_ERR : 32'h0) |
                             (done_irq ? 32'h1 << line_of(cur) : 32'h0);
   wire [31:0] next_irq    = (irq_line & ~irq_ack_i) | irq_set;

   assign step_ch[0] = cur;
   assign step_ch[1] = pair;

   // stream dst steps alongside its source
   for (genvar k = 0; k < 2; k++) begin : g_step
      dma_xy_step u_step (
         .addr_i    (cur_addr[step_ch[k]]),
         .xcnt_i    (xcnt[step_ch[k]]),
         .ycnt_i    (ycnt[step_ch[k]]),
         .x_load_i  (cnt_load(param[step_ch[k]].x_count)),
         .x_mod_i   (param[step_ch[k]].x_mod),
         .y_mod_i   (param[step_ch[k]].y_mod),
         .two_d_i   (param[step_ch[k]].cfg.two_d),
         .addr_o    (s_addr[k]),
         .xcnt_o    (s_x[k]),
         .ycnt_o    (s_y[k]),
         .row_end_o (s_row[k]),
         .buf_end_o (s_end[k])
      );
   end

   // requests: peripherals by their strobe, streams when both ends are live
   always_comb begin
      req = '0;
      for (int c = 0; c < int'(`DMA_NPER_CH); c++) begin
         req[c] = active[c] & (desc_pend[c] | per_req_i[c]);
      end
      for (int c = int'(`DMA_MS_FIRST); c < `DMA_NCH; c += 2) begin
         req[c]   = desc_pend[c] |
                    (active[c] & active[c+1] & ~desc_pend[c+1]);
         req[c+1] = desc_pend[c+1];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st          <= dma_pkg::ST_IDLE;
         cur         <= 4'h0;
         fidx        <= 3'h0;
         mem_o       <= '0;
         per_sel_o   <= 9'h0;
         per_ack_o   <= 9'h0;
         per_wdata_o <= 32'h0;
      end else if (abort) begin
         st        <= dma_pkg::ST_IDLE;
         mem_o.req <= 1'b0;
         per_sel_o <= 9'h0;
         per_ack_o <= 9'h0;
      end else begin
         case (st)
            dma_pkg::ST_IDLE: begin
               if (gnt_v) begin
                  cur <= gnt_ch;
                  if (desc_pend[gnt_ch]) begin
                     st    <= dma_pkg::ST_FETCH;
                     fidx  <= 3'h0;
                     mem_o <= '{1'b1, 1'b0, desc_ptr[gnt_ch], 32'h0};
                  end else if (gnt_rd) begin
                     st        <= dma_pkg::ST_READ;
                     per_sel_o <= gnt_sel;
                     mem_o     <= '{1'b1, 1'b0, cur_addr[gnt_ch], 32'h0};
                  end else begin
                     st        <= dma_pkg::ST_CAPT;
                     per_sel_o <= gnt_sel;
                  end
               end
            end
            dma_pkg::ST_FETCH: begin
               if (mem_gnt_i) mem_o.req <= 1'b0;
               if (mem_rvalid_i) begin
                  fidx <= next_fidx;
                  if (fetch_last) begin
                     st <= dma_pkg::ST_IDLE;
                  end else begin
                     mem_o <= '{1'b1, 1'b0, fetch_addr, 32'h0};
                  end
               end
            end
            dma_pkg::ST_READ: begin
               if (mem_gnt_i) mem_o.req <= 1'b0;
               if (mem_rvalid_i) begin
                  if (is_stream) begin
                     st    <= dma_pkg::ST_WRITE;
                     mem_o <= '{1'b1, 1'b1, cur_addr[pair], mem_rdata_i};
                  end else begin
                     st          <= dma_pkg::ST_STEP;
                     per_wdata_o <= mem_rdata_i;
                     per_ack_o   <= per_sel_o;
                  end
               end
            end
            dma_pkg::ST_CAPT: begin
               st        <= dma_pkg::ST_WRITE;
               per_ack_o <= per_sel_o;
               mem_o     <= '{1'b1, 1'b1, cur_addr[cur], per_rdata_i};
            end
            dma_pkg::ST_WRITE: begin
               per_ack_o <= 9'h0;
               if (mem_gnt_i) begin
                  mem_o.req <= 1'b0;
                  st        <= dma_pkg::ST_STEP;
               end
            end
            dma_pkg::ST_STEP: begin
               per_ack_o <= 9'h0;
               per_sel_o <= 9'h0;
               st        <= dma_pkg::ST_IDLE;
            end
            default: st <= dma_pkg::ST_IDLE;
         endcase
      end
   end

   // channel parameter and progress arrays
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         active    <= 16'h0;
         desc_pend <= 16'h0;
         for (int c = 0; c < `DMA_NCH; c++) begin
            param[c]    <= '0;
            cur_addr[c] <= 32'h0;
            desc_ptr[c] <= 32'h0;
            nextp[c]    <= 32'h0;
            xcnt[c]     <= 17'h0;
            ycnt[c]     <= 17'h0;
         end
      end else begin
         if (fetch_hit) begin
            if (pc.cfg.flow == dma_pkg::FLOW_ARRAY) begin
               // only the low half moves: the page stays fixed
               cur_addr[cur]  <= {pc.start[`HALF_HI],
                                  mem_rdata_i[`HALF_LO]};
               xcnt[cur]      <= cnt_load(pc.x_count);
               ycnt[cur]      <= cnt_load(pc.y_count);
               desc_pend[cur] <= 1'b0;
            end else begin
               case (fidx)
                  `DESC_NEXT: nextp[cur] <= mem_rdata_i;
                  `DESC_START: begin
                     param[cur].start <= mem_rdata_i;
                     cur_addr[cur]    <= mem_rdata_i;
                  end
                  `DESC_COUNTS: begin
                     param[cur].x_count <= mem_rdata_i[`HALF_HI];
                     param[cur].y_count <= mem_rdata_i[`HALF_LO];
                     xcnt[cur] <= cnt_load(mem_rdata_i[`HALF_HI]);
                     ycnt[cur] <= cnt_load(mem_rdata_i[`HALF_LO]);
                  end
                  `DESC_MODS: begin
                     param[cur].x_mod <= mem_rdata_i[`HALF_HI];
                     param[cur].y_mod <= mem_rdata_i[`HALF_LO];
                  end
                  default: begin
                     param[cur].cfg <= fetched_cfg;
                     active[cur]    <= fetched_cfg.enable;
                     desc_pend[cur] <= 1'b0;
                  end
               endcase
            end
         end
         if (step_now && !abort) begin
            for (int k = 0; k < 2; k++) begin
               if (k == 0 || is_stream) begin
                  if (!done_end) begin
                     cur_addr[step_ch[k]] <= s_addr[k];
                     xcnt[step_ch[k]]     <= s_x[k];
                     ycnt[step_ch[k]]     <= s_y[k];
                  end else begin
                     case (param[step_ch[k]].cfg.flow)
                        dma_pkg::FLOW_STOP: begin
                           active[step_ch[k]] <= 1'b0;
                        end
                        dma_pkg::FLOW_AUTO: begin
                           cur_addr[step_ch[k]] <=
                              param[step_ch[k]].start;
                           xcnt[step_ch[k]] <=
                              cnt_load(param[step_ch[k]].x_count);
                           ycnt[step_ch[k]] <=
                              cnt_load(param[step_ch[k]].y_count);
                        end
                        dma_pkg::FLOW_LIST: begin
                           desc_ptr[step_ch[k]]  <= nextp[step_ch[k]];
                           desc_pend[step_ch[k]] <= 1'b1;
                        end
                        default: begin
                           desc_ptr[step_ch[k]] <=
                              desc_ptr[step_ch[k]] + `WORD_BYTES;
                           desc_pend[step_ch[k]] <= 1'b1;
                        end
                     endcase
                  end
               end
            end
         end
         if (abort) active[cur] <= 1'b0;
         // a load from the user side overrides the engine's update
         if (cfg_we_i && cfg_ok) begin
            param[cfg_ch_i]     <= cfg_param_i;
            cur_addr[cfg_ch_i]  <= cfg_param_i.start;
            desc_ptr[cfg_ch_i]  <= cfg_param_i.start;
            xcnt[cfg_ch_i]      <= cnt_load(cfg_param_i.x_count);
            ycnt[cfg_ch_i]      <= cnt_load(cfg_param_i.y_count);
            active[cfg_ch_i]    <= cfg_param_i.cfg.enable;
            desc_pend[cfg_ch_i] <= cfg_desc_i & cfg_param_i.cfg.enable;
         end
      end
   end

   // lines stay up until acknowledged; a new event beats its own clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_line   <= 32'h0;
         core_irq_o <= 7'h0;
         low_mask   <= `LOW_PRIO_RESET;
      end else begin
         irq_line   <= next_irq;
         core_irq_o <= core_map(next_irq);
         if (prio_we_i) low_mask <= prio_low_i;
      end
   end

   assign periph_irq_o = irq_line;
   assign active_o     = active;

   wire [31:0] exp_x_addr = cur_addr[cur] +
                            {{14{pc.x_mod[15]}}, pc.x_mod, 2'b00};
   wire        step_hold  = step_now & ~cfg_we_i & ~abort;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_irq_held: assert property (
      1'b1 |=> ((($past(irq_line) & ~$past(irq_ack_i)) & ~irq_line) == '0))
      else $error("interrupt line dropped without acknowledge");
   a_err_line: assert property (
      abort |=> periph_irq_o[`LINE_ERR])
      else $error("bus error did not raise the shared error line");
   a_core_ppi: assert property (
      core_irq_o[`CORE_PPI] == periph_irq_o[`LINE_CH0])
      else $error("video channel line not mapped to its core input");
   a_core_sport: assert property (
      core_irq_o[`CORE_SPORT] == (|periph_irq_o[12:9]))
      else $error("serial port lines not mapped to their core input");
   a_done_line: assert property (
      (step_hold && !is_stream && done_end && pc.cfg.irq_en)
      |=> periph_irq_o[line_of(cur)])
      else $error("peripheral channel completion line missing");
   a_stream_line: assert property (
      (step_hold && is_stream && done_end && pc.cfg.irq_en)
      |=> (periph_irq_o[`LINE_MS0] | periph_irq_o[`LINE_MS1])
          && core_irq_o[`CORE_MEM])
      else $error("memory stream completion line missing");
   a_elem_step: assert property (
      (step_hold && !is_stream && !s_row[0])
      |=> cur_addr[cur] == $past(exp_x_addr))
      else $error("element step not applied to the address");
   a_stop_done: assert property (
      (step_hold && done_end && pc.cfg.flow == dma_pkg::FLOW_STOP)
      |=> !active[cur] && st == dma_pkg::ST_IDLE)
      else $error("single buffer did not stop at its end");
   a_auto_reload: assert property (
      (step_hold && done_end && pc.cfg.flow == dma_pkg::FLOW_AUTO)
      |=> cur_addr[cur] == pc.start && active[cur])
      else $error("autobuffer did not reload its start address");
   a_list_next: assert property (
      (step_hold && done_end && pc.cfg.flow == dma_pkg::FLOW_LIST)
      |=> desc_pend[cur] && desc_ptr[cur] == nextp[cur])
      else $error("linked descriptor not queued after buffer end");
   a_array_page: assert property (
      (fetch_hit && !cfg_we_i && !abort &&
       pc.cfg.flow == dma_pkg::FLOW_ARRAY)
      |=> cur_addr[cur][`HALF_HI] == pc.start[`HALF_HI])
      else $error("array descriptor left the common page");
   a_grant_lowest: assert property (
      (st == dma_pkg::ST_IDLE && gnt_v && !low_mask[gnt_ch])
      |-> (req & ~low_mask & 16'((16'h1 << gnt_ch) - 16'h1)) == '0)
      else $error("a lower numbered channel was passed over");
   a_grant_low: assert property (
      (gnt_v && low_mask[gnt_ch]) |-> (req & ~low_mask) == '0)
      else $error("low priority channel won over a normal one");

endmodule : multichannel_dma_controller

//--- verilog/dma_regs.svh
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH

`define DMA_NCH         16
`define DMA_NPER_CH     4'h9
`define DMA_MS_FIRST    4'hc
`define DMA_MS1_FIRST   4'he
`define LOW_PRIO_RESET  16'h0180

`define DESC_NEXT       3'h0
`define DESC_START      3'h1
`define DESC_COUNTS     3'h2
`define DESC_MODS       3'h3
`define DESC_LAST_LIST  3'h4
`define DESC_LAST_ARRAY 3'h0
`define WORD_BYTES      32'h4
`define HALF_HI         31:16
`define HALF_LO         15:0
`define CFG_W           7

`define CNT_FULL        17'h10000
`define CNT_ONE         17'h00001

`define LINE_ERR        5'h01
`define LINE_CH0        5'h08
`define LINE_SPORT_LO   5'h09
`define LINE_SPI_LO     5'h0d
`define LINE_UART_HI    5'h10
`define LINE_MS0        5'h1d
`define LINE_MS1        5'h1e

`define CORE_ERR        3'h0
`define CORE_PPI        3'h1
`define CORE_SPORT      3'h2
`define CORE_SPI_UART   3'h3
`define CORE_MEM        3'h6

`endif

//--- verilog/dma_pkg.sv
package dma_pkg;

   typedef enum logic [1:0] {
      FLOW_STOP,
      FLOW_AUTO,
      FLOW_LIST,
      FLOW_ARRAY
   } flow_t;

   typedef struct packed {
      logic  enable;
      logic  to_mem;
      logic  two_d;
      flow_t flow;
      logic  irq_en;
      logic  irq_row;
   } chan_cfg_t;

   typedef struct packed {
      logic [31:0]        start;
      logic [15:0]        x_count;
      logic [15:0]        y_count;
      logic signed [15:0] x_mod;
      logic signed [15:0] y_mod;
      chan_cfg_t          cfg;
   } chan_param_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_READ,
      ST_CAPT,
      ST_WRITE,
      ST_STEP
   } eng_state_t;

endpackage : dma_pkg

//--- verilog/dma_arbiter.sv
`timescale 1ns/1ns
`include "dma_regs.svh"

module dma_arbiter (
   input  wire logic [15:0] req_i,
   input  wire logic [15:0] low_i,
   output logic             valid_o,
   output logic [3:0]       ch_o
);

   function automatic logic [3:0] first_idx(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = `DMA_NCH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : first_idx

   // low-priority requesters only win when no normal one is waiting
   wire [15:0] hi_req = req_i & ~low_i;
   wire [15:0] lo_req = req_i & low_i;

   assign valid_o = |req_i;
   assign ch_o    = (|hi_req) ? first_idx(hi_req) : first_idx(lo_req);

endmodule : dma_arbiter

//--- verilog/dma_xy_step.sv
`timescale 1ns/1ns
`include "dma_regs.svh"

module dma_xy_step (
   input  wire logic [31:0]        addr_i,
   input  wire logic [16:0]        xcnt_i,
   input  wire logic [16:0]        ycnt_i,
   input  wire logic [16:0]        x_load_i,
   input  wire logic signed [15:0] x_mod_i,
   input  wire logic signed [15:0] y_mod_i,
   input  wire logic               two_d_i,
   output logic [31:0]             addr_o,
   output logic [16:0]             xcnt_o,
   output logic [16:0]             ycnt_o,
   output logic                    row_end_o,
   output logic                    buf_end_o
);

   // at a row end the row step replaces the element step
   wire [15:0] step_el = row_end_o ? y_mod_i : x_mod_i;
   wire [31:0] step_b  = {{14{step_el[15]}}, step_el, 2'b00};

   assign row_end_o = (xcnt_i <= `CNT_ONE);
   assign buf_end_o = row_end_o & (~two_d_i | (ycnt_i <= `CNT_ONE));
   assign addr_o    = addr_i + step_b;
   assign xcnt_o    = row_end_o ? x_load_i : xcnt_i - `CNT_ONE;
   assign ycnt_o    = row_end_o ? ycnt_i - `CNT_ONE : ycnt_i;

endmodule : dma_xy_step

//--- tb/dma_mem_model.sv
`timescale 1ns/1ns
module dma_mem_model (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire dma_pkg::mem_req_t mem_i,
   input  wire logic              slow_i,
   output logic                   gnt_o,
   output logic                   rvalid_o,
   output logic [31:0]            rdata_o
);
   logic [1:0] hold;
   wire        ready = !slow_i || (hold == 2'h2);
   // slow mode stalls each grant; idle data toggles so nothing stale looks valid
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gnt_o <= 1'b0;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0;
         hold <= 2'h0;
      end else begin
         gnt_o <= mem_i.req && !gnt_o && ready;
         hold <= (mem_i.req && !gnt_o && !ready) ? hold + 2'h1 : 2'h0;
         rvalid_o <= gnt_o && !mem_i.we;
         rdata_o <= (gnt_o && !mem_i.we) ? mem_i.addr ^ 32'h00a50000 : ~rdata_o;
      end
   end
endmodule : dma_mem_model

//--- tb/test_multichannel_dma_controller.sv
`timescale 1ns/1ns
module test_multichannel_dma_controller;
   logic                 clk_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   logic                 cfg_we_i = 1'b0;
   logic [3:0]           cfg_ch_i = 4'h0;
   dma_pkg::chan_param_t cfg_param_i = '0;
   logic [8:0]           per_req_i = 9'h0;
   logic [8:0]           per_sel_o, per_ack_o;
   logic [31:0]          irq_ack_i = 32'h0;
   logic [31:0]          per_wdata_o, periph_irq_o, rdata, a, b;
   logic [31:0]          seed = 32'h0000002f;
   logic [6:0]           core_irq_o;
   logic [15:0]          active_o;
   dma_pkg::mem_req_t    mem_o;
   logic                 gnt, rvalid;
   logic                 slow = 1'b0, err = 1'b0;
   int                   n_mismatch = 0, total_checks = 0, cyc = 0;
   always #4 clk_i = ~clk_i;
   multichannel_dma_controller dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cfg_we_i(cfg_we_i), .cfg_ch_i(cfg_ch_i), .cfg_desc_i(1'b0),
      .cfg_param_i(cfg_param_i), .prio_we_i(1'b0), .prio_low_i(16'h0),
      .per_req_i(per_req_i), .per_rdata_i(32'h0), .per_sel_o(per_sel_o),
      .per_ack_o(per_ack_o), .per_wdata_o(per_wdata_o), .mem_o(mem_o),
      .mem_gnt_i(gnt), .mem_rvalid_i(rvalid), .mem_rdata_i(rdata),
      .mem_err_i(err), .irq_ack_i(irq_ack_i), .periph_irq_o(periph_irq_o),
      .core_irq_o(core_irq_o), .active_o(active_o));
   dma_mem_model mem_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_i(mem_o),
      .slow_i(slow), .gnt_o(gnt), .rvalid_o(rvalid), .rdata_o(rdata));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction : lfsr
   function automatic int core_of(input int c);
      return (c == 0) ? 1 : (c < 5) ? 2 : 3;
   endfunction : core_of
   task automatic check(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic report_and_stop;
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      check("idle", 32'h0, {16'h0, active_o} | periph_irq_o);
      for (int c = 0; c < 9; c++) begin
         seed = lfsr(seed);
         a = {seed[31:2], 2'b00};
         @(posedge clk_i);
         slow <= seed[3];
         cfg_we_i <= 1'b1;
         cfg_ch_i <= c[3:0];
         cfg_param_i <= '{a, 16'h2, 16'h1, 16'sh1, 16'sh1, '{1'b1, 1'b0,
            seed[4], dma_pkg::FLOW_STOP, 1'b1, 1'b0}};
         per_req_i[c] <= 1'b1;
         @(posedge clk_i);
         cfg_we_i <= 1'b0;
         for (int k = 0; k < 2; k++) begin
            for (int w = 0; w < 40 && per_ack_o[c] !== 1'b1; w++)
               @(negedge clk_i);
            check("tx word", (a + 4 * k) ^ 32'h00a50000, per_wdata_o);
            check("select", 32'(9'h1 << c), {23'h0, per_sel_o});
            @(negedge clk_i);
         end
         @(posedge clk_i);
         per_req_i <= 9'h0;
         repeat (4) @(negedge clk_i);
         check("active", 32'h0, {31'h0, active_o[c]});
         check("line", 32'h1, {31'h0, periph_irq_o[8 + c]});
         check("core", 32'h1, {31'h0, core_irq_o[core_of(c)]});
         @(posedge clk_i);
         irq_ack_i[8 + c] <= 1'b1;
         @(posedge clk_i);
         irq_ack_i <= 32'h0;
         @(negedge clk_i);
         check("cleared", 32'h0, periph_irq_o);
      end
      // stream 0 copies a to b, both ends reloading after every word
      seed = lfsr(seed);
      b = {seed[31:2], 2'b00};
      @(posedge clk_i);
      slow <= 1'b0;
      cfg_we_i <= 1'b1;
      cfg_ch_i <= 4'hd;
      cfg_param_i <= '{b, 16'h1, 16'h1, 16'sh0, 16'sh0, '{1'b1, 1'b1,
         1'b0, dma_pkg::FLOW_AUTO, 1'b1, 1'b0}};
      @(posedge clk_i);
      cfg_ch_i <= 4'hc;
      cfg_param_i.start <= a;
      @(posedge clk_i);
      cfg_we_i <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         for (int w = 0; w < 40 && {mem_o.req, mem_o.we} !== 2'b11; w++)
            @(negedge clk_i);
         check("copy addr", b, mem_o.addr);
         check("copy data", a ^ 32'h00a50000, mem_o.wdata);
         repeat (3) @(negedge clk_i);
      end
      check("stream line", 32'h1, {31'h0, periph_irq_o[29]});
      check("stream core", 32'h1, {31'h0, core_irq_o[6]});
      // a bus error stops the running stream
      @(posedge clk_i);
      err <= 1'b1;
      for (int w = 0; w < 40 && active_o[12] !== 1'b0; w++)
         @(negedge clk_i);
      check("abort stop", 32'h0, {31'h0, active_o[12]});
      check("abort line", 32'h1, {31'h0, periph_irq_o[1]});
      @(posedge clk_i);
      err <= 1'b0;
      irq_ack_i <= 32'hffffffff;
      @(posedge clk_i);
      irq_ack_i <= 32'h0;
      // a load aimed at a missing channel is a configuration fault
      @(posedge clk_i);
      cfg_we_i <= 1'b1;
      cfg_ch_i <= 4'h9;
      @(posedge clk_i);
      cfg_we_i <= 1'b0;
      @(negedge clk_i);
      check("error line", 32'h2, periph_irq_o);
      check("error core", 32'h1, {31'h0, core_irq_o[0]});
      report_and_stop();
   end
endmodule : test_multichannel_dma_controller
